// File: pkg/pdil_pkg.sv
// Package of the diagnosis and interrupt logic: flag layout, carriers,
// state codes and timing constants.
// Assumes one 10 MHz clock and host accesses presented as plain strobes.
//
// Function
// RL1 - Any protection or warning event sets its sticky flag and pulls interrupt low.
// RL2 - Interrupt stays low while any unmasked flag pends; released when all cleared.
// RL3 - After fault shutdown or soft reset, set reset-occurred flag at next start-up.
// RL4 - Reset-occurred mask reloads from fuses each reset; host writes cannot change it.
// RL5 - Buck current limit keeps running, sets maskable flag, clear blocked while active.
// RL6 - Linear current limit keeps running, sets maskable flag, clear blocked while active.
// RL7 - Buck under 0.35 V for 1 ms is disabled; unmaskable short flag set.
// RL8 - Linear under 0.3 V for 1 ms is disabled; unmaskable short flag set.
// RL9 - Thermal warning sets maskable flag; clear blocked while die stays hot.
// RL10 - Thermal shutdown disables all rails, general outputs low, unmaskable held flag.
// RL11 - Supply overvoltage disables all rails, outputs low, unmaskable held flag.
// RL12 - Buck good rise and fall both set one flag, each with its own mask.
// RL13 - Linear good rise and fall both set one flag, each with its own mask.
// RL14 - Power-ok pin going inactive sets a maskable write-one-clear flag.
// RL15 - Pin status reads 1 when valid; polarity only flips the pin level.
// RL16 - External clock appearing, vanishing, or absent while detecting sets maskable flag.
// RL17 - Measurement completion sets a maskable flag without a status bit.
// RL18 - Undervoltage lockout falling shuts down, defaults registers, raises no flag.
// RL19 - Leaving undervoltage lockout defaults registers, loads fuses, sets reset flag.
// RL20 - Soft reset shuts down, then powers up with defaults and reset flag set.
// RL21 - Host requests soft reset by writing 1; bit self-clears, serial port untouched.
// RL22 - Writing 1 clears a flag; writing 0 leaves it unchanged.

package pdil_pkg;

   // Rails: index 0,1 are bucks, 2,3 are linear regulators
   localparam int RAILS = 4;

   typedef struct packed {
      logic [RAILS-1:0] en;
      logic [RAILS-1:0] low;
      logic [RAILS-1:0] curlim;
      logic [RAILS-1:0] good;
   } pdil_rail_t;

   typedef struct packed {
      logic [RAILS-1:0] curlim;
      logic [RAILS-1:0] good_rise;
      logic [RAILS-1:0] good_fall;
      logic hot_warning_mask;
      logic power_ok_pin_mask;
      logic sync_clk_mask;
      logic meas_ready_mask;
   } pdil_mask_t;

   // Flag layout, MSB first; the index constants below follow it
   typedef struct packed {
      logic [1:0] linreg_curlim_flag;
      logic [1:0] buck_curlim_flag;
      logic [1:0] linreg_short_flag;
      logic [1:0] buck_short_flag;
      logic hot_warning_flag;
      logic hot_shutdown_flag;
      logic supply_overvolt_flag;
      logic [1:0] linreg_good_flag;
      logic [1:0] buck_good_flag;
      logic power_ok_pin_flag;
      logic sync_clk_flag;
      logic meas_ready_flag;
      logic reset_occurred_flag;
   } pdil_flag_t;

   localparam int FLAGS = 19;
   localparam int FB_CURLIM = 15;
   localparam int FB_SHORT = 11;
   localparam int FB_HOTWARN = 10;
   localparam int FB_HOTSD = 9;
   localparam int FB_OVP = 8;
   localparam int FB_GOOD = 4;
   localparam int FB_POK = 3;
   localparam int FB_SYNC = 2;
   localparam int FB_MEAS = 1;
   localparam int FB_RESET = 0;

   typedef struct packed {
      logic [RAILS-1:0] curlim_state;
      logic [RAILS-1:0] good_state;
      logic hot_warning_state;
      logic hot_shutdown_state;
      logic supply_overvolt_state;
      logic power_ok_pin_state;
      logic sync_clk_state;
   } pdil_state_t;

   typedef enum logic [2:0] {
      ST_RUN  = 3'b001,
      ST_DOWN = 3'b010,
      ST_BOOT = 3'b100
   } pdil_mode_t;

   // Timing
   localparam int CLK_PERIOD_NS = 100;
   localparam int SHORT_TIME_MS = 1;
   localparam int SHORT_CYC = (SHORT_TIME_MS * 1000000) / CLK_PERIOD_NS;
   localparam int SHORT_CNT_W = 14;
   localparam logic [3:0] SOFT_DOWN_CYC = 4'h8;

   // Values after reset
   localparam logic [FLAGS-1:0] FLAGS_RST = 19'h00000;
   localparam logic [RAILS-1:0] RAIL_OFF_RST = 4'h0;

endpackage

// File: hdl/pdil_short_det.sv
// Short-circuit and overload detector for one rail.
// Assumes the low-output comparator is already synchronous to ref_clk.
`timescale 1ns/10ps
`default_nettype none

module pdil_short_det
#(
   parameter int unsigned LIMIT = 10000
)
(
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic rail_on,
   input wire logic rail_low,
   output logic short_hit
);
   import pdil_pkg::*;

   localparam logic [SHORT_CNT_W-1:0] LAST = SHORT_CNT_W'(LIMIT - 1);

   logic [SHORT_CNT_W-1:0] count_ff;
   logic [SHORT_CNT_W-1:0] nxt_count;
   logic hit_ff;
   logic nxt_hit;

   // One counter serves both start-up and run-time cases: it starts at
   // enable and restarts whenever the output recovers above threshold
   always_comb
   begin
      nxt_count = count_ff;
      nxt_hit = 1'b0;
      if (!reset_n || !rail_on || !rail_low)
      begin
         nxt_count = '0;
      end
      else if (count_ff == LAST)
      begin
         nxt_hit = 1'b1;
      end
      else
      begin
         nxt_count = count_ff + SHORT_CNT_W'(1);
      end
   end

   always_ff @(posedge ref_clk)
   begin
      count_ff <= nxt_count;
      hit_ff <= nxt_hit;
   end

   assign short_hit = hit_ff;

endmodule

`default_nettype wire

// File: hdl/pdil_top.sv
// Diagnosis flags, masks and interrupt output of the power manager.
// Assumes all event levels are synchronous to ref_clk and that the
// host presents write-one-clear strobes one cycle wide.
`timescale 1ns/10ps
`default_nettype none

module pdil_top
#(
   parameter int unsigned SHORT_LIMIT = pdil_pkg::SHORT_CYC
)
(
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire pdil_pkg::pdil_rail_t rail,
   input wire pdil_pkg::pdil_mask_t mask,
   input wire logic otp_reset_mask,
   input wire pdil_pkg::pdil_flag_t flag_clear,
   input wire logic soft_reset_request,
   input wire logic hot_warning_level,
   input wire logic hot_shutdown_level,
   input wire logic overvolt_level,
   input wire logic power_ok_valid,
   input wire logic power_ok_polarity,
   input wire logic clk_detect_en,
   input wire logic ext_clk_present,
   input wire logic meas_done,
   input wire logic gpo_a_req,
   input wire logic gpo_b_req,
   output pdil_pkg::pdil_flag_t flags,
   output pdil_pkg::pdil_state_t states,
   output logic [pdil_pkg::RAILS-1:0] rail_off,
   output logic general_output_a,
   output logic general_output_b,
   output logic power_ok_pin,
   output logic linear_event_summary,
   output logic irq_out_n
);
   import pdil_pkg::*;

   pdil_mode_t mode_ff;
   pdil_mode_t nxt_mode;
   logic [3:0] down_cnt_ff;
   logic [3:0] nxt_down_cnt;
   logic fault_down_ff;
   logic nxt_fault_down;
   logic reset_mask_ff;
   logic nxt_reset_mask;

   logic [FLAGS-1:0] flag_ff;
   logic [FLAGS-1:0] nxt_flag;
   logic [FLAGS-1:0] flag_set;
   logic [FLAGS-1:0] flag_clr;
   logic [FLAGS-1:0] irq_enable;

   logic [RAILS-1:0] good_prev_ff;
   logic pok_prev_ff;
   logic ext_prev_ff;
   logic det_prev_ff;
   logic [RAILS-1:0] off_ff;
   logic [RAILS-1:0] nxt_off;
   logic [RAILS-1:0] short_hit;
   logic [RAILS-1:0] rail_off_ff;
   logic [RAILS-1:0] nxt_rail_off;

   pdil_state_t state_ff;
   logic gpo_a_ff;
   logic gpo_b_ff;
   logic pok_pin_ff;
   logic lin_sum_ff;
   logic irq_n_ff;
   logic nxt_irq_n;
   logic all_off;

   // Detectors only watch enabled rails in run mode that no short has latched off
   genvar gi;
   generate
      for (gi = 0; gi < RAILS; gi++)
      begin : g_short
         pdil_short_det #(
            .LIMIT(SHORT_LIMIT)
         ) u_det (
            .ref_clk(ref_clk),
            .reset_n(reset_n),
            .rail_on(rail.en[gi] && !off_ff[gi] && mode_ff == ST_RUN),
            .rail_low(rail.low[gi]),
            .short_hit(short_hit[gi])
         );
      end
   endgenerate

   // RL10 RL11 global shutdown
   assign all_off = hot_shutdown_level || overvolt_level ||
                    mode_ff != ST_RUN;

   // Power-up and soft reset sequencing; reset_n is the supply POR
   always_comb
   begin
      nxt_mode = mode_ff;
      nxt_down_cnt = down_cnt_ff;
      nxt_fault_down = fault_down_ff;
      if (!reset_n)
      begin
         // RL18 RL19 lockout: defaults now, start-up on release
         nxt_mode = ST_BOOT;
         nxt_down_cnt = 4'h0;
         nxt_fault_down = 1'b0;
      end
      else
      begin
         unique case (mode_ff)
            ST_RUN:
            begin
               // RL20 RL21 soft reset strobe self-clears
               if (soft_reset_request)
               begin
                  nxt_mode = ST_DOWN;
                  nxt_down_cnt = SOFT_DOWN_CYC;
               end
               // RL3 fault shutdown noted for the next start-up
               if (hot_shutdown_level || overvolt_level)
               begin
                  nxt_fault_down = 1'b1;
               end
               else if (fault_down_ff)
               begin
                  nxt_fault_down = 1'b0;
               end
            end
            ST_DOWN:
            begin
               nxt_down_cnt = down_cnt_ff - 4'h1;
               if (down_cnt_ff == 4'h1)
               begin
                  nxt_mode = ST_BOOT;
               end
            end
            ST_BOOT:
            begin
               nxt_mode = ST_RUN;
            end
            default:
            begin
               nxt_mode = ST_BOOT;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk)
   begin
      mode_ff <= nxt_mode;
      down_cnt_ff <= nxt_down_cnt;
      fault_down_ff <= nxt_fault_down;
   end

   // RL4 mask comes only from fuses, reloaded during every reset
   always_comb
   begin
      nxt_reset_mask = reset_mask_ff;
      if (!reset_n || mode_ff == ST_DOWN)
      begin
         nxt_reset_mask = otp_reset_mask;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      reset_mask_ff <= nxt_reset_mask;
   end

   // Events that set flags this cycle
   always_comb
   begin
      flag_set = '0;
      for (int i = 0; i < RAILS; i++)
      begin
         // RL5 RL6 level set keeps the flag while limit persists
         flag_set[FB_CURLIM+i] = rail.curlim[i] &&
                                 (!mask.curlim[i] || flag_ff[FB_CURLIM+i]);
         // RL7 RL8 unmaskable short flag
         flag_set[FB_SHORT+i] = short_hit[i];
         // RL12 RL13 rise and fall each gated by own mask
         flag_set[FB_GOOD+i] =
            (rail.good[i] && !good_prev_ff[i] && !mask.good_rise[i]) ||
            (!rail.good[i] && good_prev_ff[i] && !mask.good_fall[i]);
      end
      // RL9 warning held while die is hot
      // A mask raised later must not let a clear drop a live warning
      flag_set[FB_HOTWARN] = hot_warning_level &&
                             (!mask.hot_warning_mask || flag_ff[FB_HOTWARN]);
      // RL10 shutdown flag held while hot
      flag_set[FB_HOTSD] = hot_shutdown_level;
      // RL11 overvoltage flag held while high
      flag_set[FB_OVP] = overvolt_level;
      // RL14 pin valid to invalid
      flag_set[FB_POK] = pok_prev_ff && !power_ok_valid &&
                         !mask.power_ok_pin_mask;
      // RL16 clock change or missing clock
      flag_set[FB_SYNC] = !mask.sync_clk_mask && clk_detect_en &&
                          ((det_prev_ff && ext_clk_present != ext_prev_ff) ||
                           !ext_clk_present);
      // RL17 measurement done
      flag_set[FB_MEAS] = meas_done && !mask.meas_ready_mask;
      // RL3 RL19 RL20 reset noted at start-up
      flag_set[FB_RESET] = (mode_ff == ST_BOOT) ||
                           (mode_ff == ST_RUN && fault_down_ff &&
                            !hot_shutdown_level && !overvolt_level);
   end

   // RL1 RL22 sticky flags; a set in the clear cycle wins
   always_comb
   begin
      flag_clr = FLAGS'(flag_clear);
      nxt_flag = (flag_ff & ~flag_clr) | flag_set;
      // RL18 lockout and soft reset return flags to defaults
      if (!reset_n || mode_ff == ST_DOWN)
      begin
         nxt_flag = FLAGS_RST;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      flag_ff <= nxt_flag;
   end

   // Previous samples for edge detection
   always_ff @(posedge ref_clk)
   begin
      good_prev_ff <= reset_n ? rail.good : RAIL_OFF_RST;
      pok_prev_ff <= reset_n ? power_ok_valid : 1'b0;
      ext_prev_ff <= reset_n ? ext_clk_present : 1'b0;
      det_prev_ff <= reset_n ? clk_detect_en : 1'b0;
   end

   // RL7 RL8 a shorted rail stays off until its enable drops
   always_comb
   begin
      nxt_off = off_ff & rail.en;
      nxt_off = nxt_off | short_hit;
      if (!reset_n || mode_ff == ST_DOWN)
      begin
         nxt_off = RAIL_OFF_RST;
      end
      // RL10 RL11 registered so the pin never glitches on a fault input
      nxt_rail_off = nxt_off | {RAILS{all_off}};
   end

   always_ff @(posedge ref_clk)
   begin
      off_ff <= nxt_off;
      rail_off_ff <= nxt_rail_off;
   end

   // RL2 only unmasked pending flags hold the interrupt low
   always_comb
   begin
      irq_enable = '1;
      irq_enable[FB_CURLIM +: RAILS] = ~mask.curlim;
      irq_enable[FB_HOTWARN] = !mask.hot_warning_mask;
      irq_enable[FB_POK] = !mask.power_ok_pin_mask;
      irq_enable[FB_SYNC] = !mask.sync_clk_mask;
      irq_enable[FB_MEAS] = !mask.meas_ready_mask;
      // RL4 fuse mask suppresses the reset interrupt
      irq_enable[FB_RESET] = !reset_mask_ff;
      nxt_irq_n = !(|(flag_ff & irq_enable));
      if (!reset_n)
      begin
         nxt_irq_n = 1'b1;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      irq_n_ff <= nxt_irq_n;
   end

   // Registered status, pins and summaries; forced outputs follow faults
   always_ff @(posedge ref_clk)
   begin
      if (!reset_n)
      begin
         state_ff <= '0;
         gpo_a_ff <= 1'b0;
         gpo_b_ff <= 1'b0;
         pok_pin_ff <= 1'b0;
         lin_sum_ff <= 1'b0;
      end
      else
      begin
         state_ff.curlim_state <= rail.curlim;
         state_ff.good_state <= rail.good;
         state_ff.hot_warning_state <= hot_warning_level;
         state_ff.hot_shutdown_state <= hot_shutdown_level;
         state_ff.supply_overvolt_state <= overvolt_level;
         // RL15 status is the valid sense, polarity only on the pin
         state_ff.power_ok_pin_state <= power_ok_valid;
         state_ff.sync_clk_state <= ext_clk_present;
         pok_pin_ff <= power_ok_polarity ? power_ok_valid : !power_ok_valid;
         // RL10 RL11 general outputs forced low
         gpo_a_ff <= gpo_a_req && !all_off;
         gpo_b_ff <= gpo_b_req && !all_off;
         lin_sum_ff <= |{flag_ff[FB_CURLIM+2 +: 2], flag_ff[FB_SHORT+2 +: 2],
                         flag_ff[FB_GOOD+2 +: 2]};
      end
   end

   assign flags = pdil_flag_t'(flag_ff);
   assign states = state_ff;
   assign rail_off = rail_off_ff;
   assign general_output_a = gpo_a_ff;
   assign general_output_b = gpo_b_ff;
   assign power_ok_pin = pok_pin_ff;
   assign linear_event_summary = lin_sum_ff;
   assign irq_out_n = irq_n_ff;

endmodule

`default_nettype wire

// File: verification/pdil_top_properties.sv
// Checker on the ports of the diagnosis flags and interrupt block.
// Assumes a single ref_clk domain and a bind onto pdil_top.
`timescale 1ns/10ps
`default_nettype none

module pdil_top_properties
#(
   parameter int unsigned SHORT_LIMIT = 16
)
(
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire pdil_pkg::pdil_rail_t rail,
   input wire pdil_pkg::pdil_mask_t mask,
   input wire logic hot_shutdown_level,
   input wire logic overvolt_level,
   input wire logic power_ok_valid,
   input wire logic power_ok_polarity,
   input wire pdil_pkg::pdil_flag_t flags,
   input wire pdil_pkg::pdil_state_t states,
   input wire logic [pdil_pkg::RAILS-1:0] rail_off,
   input wire logic general_output_a,
   input wire logic general_output_b,
   input wire logic power_ok_pin,
   input wire logic irq_out_n
);
   import pdil_pkg::*;

   default clocking @(posedge ref_clk);
   endclocking
   default disable iff (!reset_n);

   // Run length of a low, enabled buck 0; short runs never reach wrap
   logic [7:0] low_run_ff;
   logic [7:0] nxt_low_run;
   always_comb
   begin
      nxt_low_run = (rail.en[0] && rail.low[0]) ? low_run_ff + 8'h01 : 8'h00;
   end
   always_ff @(posedge ref_clk)
   begin
      low_run_ff <= reset_n ? nxt_low_run : 8'h00;
   end

   property p_irq_low;
      flags[FLAGS-1:1] != 18'h0 |=> !irq_out_n;
   endproperty
   a_irq_low: assert property (p_irq_low) else $error("irq not low");
   property p_irq_free;
      flags == FLAGS_RST |=> irq_out_n;
   endproperty
   a_irq_free: assert property (p_irq_free) else $error("irq stuck");
   property p_lim_hold;
      rail.curlim[0] && flags.buck_curlim_flag[0] |=> flags.buck_curlim_flag[0];
   endproperty
   a_lim_hold: assert property (p_lim_hold) else $error("limit lost");
   property p_hot_sd;
      hot_shutdown_level |=> flags.hot_shutdown_flag && !general_output_a
         && !general_output_b;
   endproperty
   a_hot_sd: assert property (p_hot_sd) else $error("hot shutdown");
   property p_ovp;
      overvolt_level |=> rail_off == 4'hF && flags.supply_overvolt_flag;
   endproperty
   a_ovp: assert property (p_ovp) else $error("overvoltage");
   property p_short;
      int'(low_run_ff) == SHORT_LIMIT + 3 |-> flags.buck_short_flag[0]
         && rail_off[0];
   endproperty
   a_short: assert property (p_short) else $error("short missed");
   property p_good_rise;
      $rose(rail.good[0]) && !mask.good_rise[0] |=> flags.buck_good_flag[0];
   endproperty
   a_good_rise: assert property (p_good_rise) else $error("good rise");
   property p_pin;
      1'h1 |=> states.power_ok_pin_state == $past(power_ok_valid)
         && power_ok_pin == ($past(power_ok_valid) == $past(power_ok_polarity));
   endproperty
   a_pin: assert property (p_pin) else $error("pin level");
endmodule

`default_nettype wire

// File: verification/pdil_host_model.sv
// Host model: turns clear and reset requests into one-cycle strobes.
// Assumes the bench raises each request for one cycle after reset.
`timescale 1ns/10ps
`default_nettype none

module pdil_host_model
(
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire pdil_pkg::pdil_flag_t clr_sel,
   input wire logic clr_go,
   input wire logic sr_go,
   output var pdil_pkg::pdil_flag_t flag_clear,
   output var logic soft_reset_request
);
   import pdil_pkg::*;

   // reset bit self-clears
   // A write lands as one strobe, so zero bits never touch a flag
   always_ff @(posedge ref_clk)
   begin
      flag_clear <= (reset_n && clr_go) ? clr_sel : FLAGS_RST;
      soft_reset_request <= reset_n && sr_go;
   end
endmodule

`default_nettype wire

// File: verification/tb.sv
// Self-checking bench of the diagnosis flags and interrupt output.
// Assumes the host model turns requests into one-cycle strobes.
`timescale 1ns/10ps
`default_nettype none

module tb;
   import pdil_pkg::*;
   localparam int unsigned SL = 16;
   logic ref_clk = 1'h0;
   logic reset_n = 1'h0;
   pdil_rail_t rail = 16'h0000;
   pdil_mask_t mask = 16'h0000;
   pdil_flag_t clr_sel = 19'h00000;
   logic otp_reset_mask = 1'h0, hot_warning_level = 1'h0;
   logic hot_shutdown_level = 1'h0, overvolt_level = 1'h0;
   logic power_ok_valid = 1'h0, power_ok_polarity = 1'h1;
   logic clk_detect_en = 1'h0, meas_done = 1'h0, ext_clk_present = 1'h0;
   logic clr_go = 1'h0, sr_go = 1'h0;
   pdil_flag_t flags, flag_clear;
   pdil_state_t states;
   logic [RAILS-1:0] rail_off;
   logic general_output_a, general_output_b, power_ok_pin;
   logic linear_event_summary, irq_out_n, soft_reset_request;
   int bad_count = 0;
   int total_checks = 0;

   // Device under test, short timer cut down to keep runs brief
   pdil_top #(.SHORT_LIMIT(SL)) i_dut
   (
      .ref_clk, .reset_n, .rail, .mask, .otp_reset_mask, .flag_clear,
      .soft_reset_request, .hot_warning_level, .hot_shutdown_level,
      .overvolt_level, .power_ok_valid, .power_ok_polarity, .clk_detect_en,
      .ext_clk_present, .meas_done, .gpo_a_req(1'h1),
      .gpo_b_req(1'h1), .flags, .states, .rail_off, .general_output_a,
      .general_output_b, .power_ok_pin, .linear_event_summary, .irq_out_n
   );

   // Host side
   pdil_host_model i_host
   (
      .ref_clk, .reset_n, .clr_sel, .clr_go, .sr_go, .flag_clear,
      .soft_reset_request
   );

   // Free-running 10 MHz clock
   initial
   begin
      forever #50 ref_clk = ~ref_clk;
   end

   task automatic chk(input logic [20:0] seen, input logic [20:0] exp);
      total_checks = total_checks + 1;
      if (seen !== exp)
      begin
         bad_count = bad_count + 1;
         $display("MISMATCH %0t: saw %h want %h", $time, seen, exp);
      end
   endtask

   // Waits past the edge so registered outputs have settled
   task automatic look(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask

   task automatic clr(input pdil_flag_t sel);
      @(posedge ref_clk);
      clr_sel <= sel;
      clr_go <= 1'h1;
      @(posedge ref_clk);
      clr_go <= 1'h0;
      look(3);
   endtask

   task automatic finish_test;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic t_boot;
      look(4);
      chk(flags, 19'h00001);
      chk(irq_out_n, 1'h0);
      clr(19'h7FFFF);
      chk({flags, irq_out_n}, 20'h00001);
      $display("boot done");
   endtask

   task automatic t_curlim;
      @(posedge ref_clk) rail.curlim <= 4'h5;
      look(3);
      chk({flags, irq_out_n}, 20'h50000);
      chk(states.curlim_state, 4'h5);
      clr(19'h7FFFF);
      chk(flags, 19'h28000);
      @(posedge ref_clk) rail.curlim <= 4'h0;
      clr(19'h7FFFF);
      chk({flags, irq_out_n}, 20'h00001);
      @(posedge ref_clk)
      begin
         mask.curlim <= 4'h4;
         rail.curlim <= 4'h4;
      end
      look(3);
      chk(flags, 19'h00000);
      @(posedge ref_clk) rail.curlim <= 4'h0;
      $display("curlim done");
   endtask

   task automatic t_thermal;
      @(posedge ref_clk) hot_warning_level <= 1'h1;
      look(3);
      chk(flags, 19'h00400);
      @(posedge ref_clk)
      begin
         hot_warning_level <= 1'h0;
         hot_shutdown_level <= 1'h1;
      end
      look(3);
      chk({rail_off, general_output_a, general_output_b,
           states.hot_shutdown_state}, 7'h79);
      clr(19'h7FFFF);
      chk(flags, 19'h00200);
      @(posedge ref_clk)
      begin
         hot_shutdown_level <= 1'h0;
         overvolt_level <= 1'h1;
      end
      look(3);
      chk(flags[10:8], 3'h3);
      @(posedge ref_clk) overvolt_level <= 1'h0;
      look(12);
      chk(flags.reset_occurred_flag, 1'h1);
      clr(19'h7FFFF);
      chk({flags, general_output_a, general_output_b}, 21'h3);
      $display("thermal done");
   endtask

   task automatic t_short;
      @(posedge ref_clk)
      begin
         rail.en <= 4'h5;
         rail.low <= 4'h5;
      end
      look(SL + 4);
      chk({rail_off, flags[14:11], linear_event_summary}, 9'h0AB);
      @(posedge ref_clk)
      begin
         rail.en <= 4'h0;
         rail.low <= 4'h0;
      end
      clr(19'h7FFFF);
      chk({rail_off, flags[14:11]}, 8'h00);
      $display("short done");
   endtask

   task automatic t_good;
      @(posedge ref_clk)
      begin
         mask.good_rise <= 4'h4;
         rail.good <= 4'h5;
         power_ok_valid <= 1'h1;
      end
      look(3);
      chk(flags, 19'h00010);
      chk(states.good_state, 4'h5);
      @(posedge ref_clk)
      begin
         rail.good <= 4'h0;
         power_ok_valid <= 1'h0;
         power_ok_polarity <= 1'h0;
         clk_detect_en <= 1'h1;
         meas_done <= 1'h1;
      end
      @(posedge ref_clk) meas_done <= 1'h0;
      look(3);
      chk(flags[7:4], 4'h5);
      chk(flags[3:1], 3'h7);
      chk({power_ok_pin, states.power_ok_pin_state}, 2'h2);
      @(posedge ref_clk) clk_detect_en <= 1'h0;
      clr(19'h00002);
      chk(flags[3:1], 3'h6);
      clr(19'h7FFFF);
      chk(flags, 19'h00000);
      @(posedge ref_clk)
      begin
         clk_detect_en <= 1'h1;
         ext_clk_present <= 1'h1;
      end
      look(3);
      chk({flags.sync_clk_flag, states.sync_clk_state}, 2'h1);
      @(posedge ref_clk) ext_clk_present <= 1'h0;
      look(2);
      chk({flags.sync_clk_flag, states.sync_clk_state}, 2'h2);
      @(posedge ref_clk) clk_detect_en <= 1'h0;
      clr(19'h00004);
      chk(flags, 19'h00000);
      $display("good done");
   endtask

   task automatic t_soft;
      @(posedge ref_clk) meas_done <= 1'h1;
      @(posedge ref_clk)
      begin
         meas_done <= 1'h0;
         otp_reset_mask <= 1'h1;
         sr_go <= 1'h1;
      end
      @(posedge ref_clk) sr_go <= 1'h0;
      look(4);
      chk({rail_off, general_output_a, general_output_b}, 6'h3C);
      look(12);
      chk({flags[18:1], irq_out_n}, 19'h00001);
      @(posedge ref_clk)
      begin
         otp_reset_mask <= 1'h0;
         sr_go <= 1'h1;
      end
      @(posedge ref_clk) sr_go <= 1'h0;
      look(16);
      chk(flags, 19'h00001);
      clr(19'h7FFFF);
      $display("soft reset done");
   endtask

   // Main sequence: reset for three cycles, then every scenario
   initial
   begin
      repeat (3) @(posedge ref_clk);
      reset_n <= 1'h1;
      t_boot;
      t_curlim;
      t_thermal;
      t_short;
      t_good;
      t_soft;
      finish_test;
   end

   // Watchdog: the whole run needs about 170 cycles
   initial
   begin
      repeat (3000) @(posedge ref_clk);
      bad_count = bad_count + 1;
      $display("MISMATCH %0t: watchdog expired", $time);
      finish_test;
   end
endmodule

bind pdil_top pdil_top_properties #(.SHORT_LIMIT(SHORT_LIMIT)) i_prop
(
   .ref_clk, .reset_n, .rail, .mask, .hot_shutdown_level, .overvolt_level,
   .power_ok_valid, .power_ok_polarity, .flags, .states, .rail_off,
   .general_output_a, .general_output_b, .power_ok_pin, .irq_out_n
);

`default_nettype wire
